// >>> verilog/cmd_front_map.svh
/*
 Constants for the serial command front end: characters, line timing, delays.
 Assumes a 25 MHz reference clock; counts are derived from it.
*/
`ifndef CMD_FRONT_MAP_SVH
`define CMD_FRONT_MAP_SVH
`define CLK_HZ 25000000
`define BAUD_SLOW 9600
`define BAUD_FAST 38400
`define DATA_BITS 8
`define STOP_BITS 1
`define CHR_CR 8'h0D
`define CHR_LF 8'h0A
`define CHR_PROMPT 8'h3E
`define CHR_QMARK 8'h3F
`define CHR_SPACE 8'h20
`define CHR_A 8'h41
`define CHR_T 8'h54
`define CHR_Z 8'h5A
`define CHR_W 8'h57
`define CHR_S 8'h53
`define CHR_R 8'h52
`define CHR_V 8'h56
`define CHR_L 8'h4C
`define CHR_P 8'h50
`define CHR_O 8'h4F
`define CHR_K 8'h4B
`define ABORT_MS 20000
`define FULL_RESET_MS 1000
`define WARM_RESET_MS 2
`define ADC_MS 7
`define WAKE_US 128
`define SLEEP_REQ_MS 1000
`define SLEEP_WARN_MS 2000
`define LED_STEP_MS 100
`define ID_LEN 6
`endif

// >>> verilog/cmd_front_pkg.sv
/*
 Types shared by the command front end.
 Assumes the constants header is compiled alongside.
*/
package cmd_front_pkg;
    typedef enum logic [2:0] {
        MSG_NONE, MSG_FULL_RESET, MSG_WARM, MSG_VOLT, MSG_SLEEP, MSG_LINEFEED, MSG_OTHER_AT,
        MSG_HEX
    } msg_kind_type;
endpackage

// >>> verilog/uart_rx_unit.sv
/*
 Receiver for 8N1 characters with a programmable bit period.
 Assumes rx has already passed two synchronising flip-flops.
*/
`timescale 1ns/10ps
`include "cmd_front_map.svh"
module uart_rx_unit #(
    parameter int DIV_W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [DIV_W-1:0] bit_period,
    input wire logic rx,
    output logic [7:0] data,
    output logic valid
);
    logic [DIV_W-1:0] cnt, next_cnt;
    logic [3:0] bitn, next_bitn;
    logic busy, next_busy;
    logic [7:0] sh, next_sh;
    logic next_valid;

    always_comb begin
        next_cnt = cnt;
        next_bitn = bitn;
        next_busy = busy;
        next_sh = sh;
        next_valid = 1'b0;
        if (!busy) begin
            if (!rx) begin
                next_busy = 1'b1;
                next_cnt = bit_period >> 1;
                next_bitn = 4'h0;
            end
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end else begin
            next_cnt = bit_period;
            next_bitn = bitn + 4'h1;
            if (bitn == 4'h0 && rx)
                next_busy = 1'b0;
            else if (bitn >= 4'h1 && bitn <= 4'(`DATA_BITS))
                next_sh = {rx, sh[7:1]};
            else if (bitn == 4'(`DATA_BITS + `STOP_BITS)) begin
                next_busy = 1'b0;
                next_valid = rx;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            bitn <= 4'h0;
            busy <= 1'b0;
            sh <= 8'h00;
            valid <= 1'b0;
        end else begin
            cnt <= next_cnt;
            bitn <= next_bitn;
            busy <= next_busy;
            sh <= next_sh;
            valid <= next_valid;
        end
    end
    assign data = sh;
endmodule

// >>> verilog/uart_tx_unit.sv
/*
 Transmitter for 8N1 characters with a programmable bit period.
 Assumes start is only raised while ready is high.
*/
`timescale 1ns/10ps
`include "cmd_front_map.svh"
module uart_tx_unit #(
    parameter int DIV_W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [DIV_W-1:0] bit_period,
    input wire logic start,
    input wire logic [7:0] data,
    output logic ready,
    output logic tx
);
    logic [DIV_W-1:0] cnt, next_cnt;
    logic [3:0] bitn, next_bitn;
    logic [9:0] sh, next_sh;
    logic busy, next_busy;

    always_comb begin
        next_cnt = cnt;
        next_bitn = bitn;
        next_sh = sh;
        next_busy = busy;
        if (!busy) begin
            if (start) begin
                next_busy = 1'b1;
                next_sh = {1'b1, data, 1'b0};
                next_cnt = bit_period;
                next_bitn = 4'h0;
            end
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end else begin
            next_cnt = bit_period;
            next_sh = {1'b1, sh[9:1]};
            next_bitn = bitn + 4'h1;
            if (bitn == 4'(`DATA_BITS + `STOP_BITS))
                next_busy = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            bitn <= 4'h0;
            sh <= 10'h3FF;
            busy <= 1'b0;
        end else begin
            cnt <= next_cnt;
            bitn <= next_bitn;
            sh <= next_sh;
            busy <= next_busy;
        end
    end
    assign tx = sh[0];
    // Ready must not look at start: start is decoded from ready upstream
    assign ready = !busy;
endmodule

// >>> verilog/cmd_front_end.sv
/*
 Serial command front end: line rate, message collection and classification,
 abort timer, power-up and reset banner, prompt, latencies, sleep and wake.
 Assumes an outside executor takes forwarded messages and reports completion.
*/
// Function
// - Line rate 9600 when rate pin low at power-up, else 38400 unless changed.
// - Characters are eight data bits, no parity, one stop bit both ways.
// - Response lines end with CR, then LF only if linefeeds enabled.
// - After power-up light five indicators in turn, send identity, newline, prompt.
// - Send prompt only when idle and ready for new characters.
// - Messages starting A,T are configuration; others hex only, forwarded onward; the code forwards only their third and later non-space characters.
// - Host ends messages with CR 0D; nothing acts before it arrives; the code sets the linefeed option on a fourth character 0 or 1 after L, before CR.
// - Partial message without CR discarded after about 20 s, one question mark.
// - Syntax error answered with a single question mark, nothing executed.
// - Spaces between command letters are ignored.
// - Full reset banner after 1000 ms with indicators; warm restart after 2 ms.
// - Supply voltage read answer begins about 7 ms after the command.
// - Receive-line pulse of at least 128 us wakes the device from low power.
// - Power control output changes 1.0 s after sleep request accepted.
// - Power control output changes 2.0 s after sleep warning issued.
// - Power control output holds normal level until low power entered.
`timescale 1ns/10ps
`include "cmd_front_map.svh"
module cmd_front_end
    import cmd_front_pkg::*;
#(
    parameter int ABORT_CYC = (`CLK_HZ / 1000) * `ABORT_MS,
    parameter int FULL_RESET_CYC = (`CLK_HZ / 1000) * `FULL_RESET_MS,
    parameter int SLEEP_REQ_CYC = (`CLK_HZ / 1000) * `SLEEP_REQ_MS,
    parameter int SLEEP_WARN_CYC = (`CLK_HZ / 1000) * `SLEEP_WARN_MS,
    parameter int ADC_CYC = (`CLK_HZ / 1000) * `ADC_MS,
    parameter int WARM_CYC = (`CLK_HZ / 1000) * `WARM_RESET_MS,
    parameter int LED_STEP_CYC = (`CLK_HZ / 1000) * `LED_STEP_MS,
    parameter logic [7:0] ID_BYTE = 8'h49
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Pins
    input wire logic rate_select,
    input wire logic power_normal_level,
    input wire logic serial_rx,
    output logic serial_tx,
    output logic [4:0] indicator,
    output logic power_control_output,
    // Executor side
    output logic [7:0] msg_char,
    output logic msg_char_valid,
    output logic msg_done,
    input wire logic exec_done,
    input wire logic sleep_warning_message
);
    localparam int WAKE_CYC = (`CLK_HZ / 1000000) * `WAKE_US;
    localparam int DIV_SLOW = `CLK_HZ / `BAUD_SLOW - 1;
    localparam int DIV_FAST = `CLK_HZ / `BAUD_FAST - 1;
    localparam int TW = 32;

    initial begin
        if (ABORT_CYC < 1 || FULL_RESET_CYC < 1 || WARM_CYC < 1 || LED_STEP_CYC < 1)
            $error("cmd_front_end: delay counts must be at least one cycle");
    end

    typedef enum logic [3:0] {
        ST_LEDS, ST_WAIT, ST_BANNER, ST_PROMPT, ST_IDLE, ST_ANSWER, ST_EXEC, ST_SLEEPWAIT,
        ST_ASLEEP
    } state_type;

    function automatic logic is_hex(input logic [7:0] c);
        is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
    endfunction

    function automatic logic [7:0] upcase(input logic [7:0] c);
        upcase = (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
    endfunction

    // Reset release and pin synchronisers
    logic [1:0] rst_sync;
    logic rst_n;
    logic [1:0] rx_sync, rate_sync;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];
    // Reset by the raw reset so the rate pin is settled before rst_n rises
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_sync <= 2'b11;
            rate_sync <= 2'b00;
        end else begin
            rx_sync <= {rx_sync[0], serial_rx};
            rate_sync <= {rate_sync[0], rate_select};
        end
    end

    // Rate is captured once after power-up; a later pin change has no effect
    logic rate_fast, rate_taken;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_fast <= 1'b0;
            rate_taken <= 1'b0;
        end else if (!rate_taken) begin
            rate_fast <= rate_sync[1];
            rate_taken <= 1'b1;
        end
    end
    logic [11:0] bit_period;
    assign bit_period = rate_fast ? 12'(DIV_FAST) : 12'(DIV_SLOW);

    logic [7:0] rx_data, tx_data;
    logic rx_valid, tx_start, tx_ready, tx_line;
    uart_rx_unit #(.DIV_W(12)) u_rx (
        .clk(ref_clk), .rst_n(rst_n), .bit_period(bit_period), .rx(rx_sync[1]),
        .data(rx_data), .valid(rx_valid)
    );
    uart_tx_unit #(.DIV_W(12)) u_tx (
        .clk(ref_clk), .rst_n(rst_n), .bit_period(bit_period), .start(tx_start),
        .data(tx_data), .ready(tx_ready), .tx(tx_line)
    );

    // Main sequencer
    state_type state, next_state;
    logic [TW-1:0] timer, next_timer;
    logic [2:0] step, next_step;
    logic [3:0] len, next_len;
    logic [7:0] c0, next_c0, c1, next_c1, c2, next_c2, c3, next_c3;
    logic bad, next_bad, lf_on, next_lf_on;
    msg_kind_type kind, next_kind;
    logic [4:0] next_indicator;
    logic next_pwr, next_tx, next_fwd_valid, next_done;
    logic [7:0] next_fwd;
    logic [7:0] ch;
    logic [TW-1:0] wake_cnt, next_wake_cnt;

    assign ch = upcase(rx_data);

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_step = step;
        next_len = len;
        next_c0 = c0;
        next_c1 = c1;
        next_c2 = c2;
        next_c3 = c3;
        next_bad = bad;
        next_lf_on = lf_on;
        next_kind = kind;
        next_indicator = 5'h1F;
        next_pwr = power_control_output;
        next_fwd = msg_char;
        next_fwd_valid = 1'b0;
        next_done = 1'b0;
        next_wake_cnt = '0;
        tx_start = 1'b0;
        tx_data = `CHR_PROMPT;
        next_tx = tx_line;
        case (state)
            ST_LEDS: begin
                next_indicator = ~(5'h01 << step);
                if (timer != '0) next_timer = timer - 1'b1;
                else begin
                    next_timer = TW'(LED_STEP_CYC - 1);
                    next_step = step + 3'd1;
                    if (step == 3'd4) begin
                        next_step = 3'd0;
                        next_state = ST_BANNER;
                    end
                end
            end
            ST_WAIT: begin
                if (timer != '0) next_timer = timer - 1'b1;
                else next_state = (kind == MSG_FULL_RESET) ? ST_LEDS : ST_BANNER;
            end
            ST_BANNER: if (tx_ready) begin
                tx_start = 1'b1;
                tx_data = (step < 3'(`ID_LEN - 2)) ? ID_BYTE : (step == 3'(`ID_LEN - 2))
                    ? `CHR_CR : `CHR_LF;
                next_step = step + 3'd1;
                if (step == 3'(`ID_LEN - 2) && !lf_on) next_step = 3'(`ID_LEN);
                if (next_step >= 3'(`ID_LEN)) next_state = ST_PROMPT;
            end
            ST_PROMPT: if (tx_ready) begin
                tx_start = 1'b1;
                tx_data = `CHR_PROMPT;
                next_state = ST_IDLE;
                next_len = 4'h0;
                next_bad = 1'b0;
                next_timer = '0;
            end
            ST_IDLE: begin
                if (len != 4'h0) next_timer = timer + 1'b1;
                if (len != 4'h0 && timer >= TW'(ABORT_CYC - 1)) begin
                    next_kind = MSG_NONE;
                    next_bad = 1'b1;
                    next_step = 3'd0;
                    next_state = ST_ANSWER;
                end else if (rx_valid) begin
                    if (ch == `CHR_CR) begin
                        next_step = 3'd0;
                        next_timer = '0;
                        next_done = !bad && !(c0 == `CHR_A && c1 == `CHR_T) && len != 4'h0;
                        if (len == 4'h0) next_state = ST_PROMPT;
                        else if (c0 == `CHR_A && c1 == `CHR_T) begin
                            next_kind = (c2 == `CHR_Z) ? MSG_FULL_RESET : (c2 == `CHR_W)
                                ? MSG_WARM : (c2 == `CHR_R) ? MSG_VOLT : (c2 == `CHR_L &&
                                (c3 == 8'h30 || c3 == 8'h31)) ? MSG_LINEFEED
                                : (c2 == `CHR_L) ? MSG_SLEEP
                                : MSG_OTHER_AT;
                            next_state = ST_ANSWER;
                        end else if (bad) begin
                            next_state = ST_ANSWER;
                        end else begin
                            next_kind = MSG_HEX;
                            next_state = ST_EXEC;
                        end
                    end else if (ch != `CHR_SPACE) begin
                        next_len = (len == 4'hF) ? len : len + 4'h1;
                        if (len == 4'h0) next_c0 = ch;
                        if (len == 4'h1) next_c1 = ch;
                        if (len == 4'h2) next_c2 = ch;
                        if (len == 4'h3) next_c3 = ch;
                        if (len == 4'h3 && c2 == `CHR_L && (ch == 8'h30 || ch == 8'h31))
                            next_lf_on = ch == 8'h31;
                        if (!(len == 4'h1 && c0 == `CHR_A && ch == `CHR_T) && !is_hex(ch)
                            && !(c0 == `CHR_A && c1 == `CHR_T))
                            next_bad = 1'b1;
                        if (!(c0 == `CHR_A && c1 == `CHR_T) && len >= 4'h2) begin
                            next_fwd = ch;
                            next_fwd_valid = 1'b1;
                        end
                    end
                end
            end
            ST_ANSWER: begin
                if (bad || kind == MSG_OTHER_AT) begin
                    if (tx_ready) begin
                        tx_start = 1'b1;
                        tx_data = (step == 3'd0) ? `CHR_QMARK : (step == 3'd1) ? `CHR_CR
                            : `CHR_LF;
                        next_step = step + 3'd1;
                        if ((step == 3'd1 && !lf_on) || step == 3'd2) next_state = ST_PROMPT;
                    end
                end else if (kind == MSG_FULL_RESET) begin
                    next_timer = TW'(FULL_RESET_CYC - 1);
                    next_step = 3'd0;
                    next_state = ST_WAIT;
                end else if (kind == MSG_WARM) begin
                    next_timer = TW'(WARM_CYC - 1);
                    next_step = 3'd0;
                    next_state = ST_WAIT;
                end else if (kind == MSG_VOLT) begin
                    next_timer = TW'(ADC_CYC - 1);
                    next_step = 3'd0;
                    next_kind = MSG_LINEFEED;
                    next_state = ST_WAIT;
                end else if (kind == MSG_SLEEP) begin
                    next_timer = TW'(SLEEP_REQ_CYC - 1);
                    next_state = ST_SLEEPWAIT;
                end else begin
                    next_state = ST_PROMPT;
                end
            end
            ST_EXEC: if (exec_done) next_state = ST_PROMPT;
            ST_SLEEPWAIT: begin
                if (timer != '0) next_timer = timer - 1'b1;
                else begin
                    next_pwr = !power_normal_level;
                    next_state = ST_ASLEEP;
                end
            end
            ST_ASLEEP: begin
                next_wake_cnt = rx_sync[1] ? '0 : wake_cnt + 1'b1;
                if (rx_sync[1] && wake_cnt >= TW'(WAKE_CYC)) begin
                    next_pwr = power_normal_level;
                    next_step = 3'd0;
                    next_state = ST_BANNER;
                end
            end
            default: next_state = ST_LEDS;
        endcase
        if (sleep_warning_message && state != ST_SLEEPWAIT && state != ST_ASLEEP) begin
            next_timer = TW'(SLEEP_WARN_CYC - 1);
            next_state = ST_SLEEPWAIT;
        end
        if (state != ST_SLEEPWAIT && state != ST_ASLEEP) next_pwr = power_normal_level;
        next_tx = tx_line;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_LEDS;
            timer <= TW'(LED_STEP_CYC - 1);
            step <= 3'd0;
            len <= 4'h0;
            c0 <= 8'h00;
            c1 <= 8'h00;
            c2 <= 8'h00;
            c3 <= 8'h00;
            bad <= 1'b0;
            lf_on <= 1'b0;
            kind <= MSG_NONE;
            indicator <= 5'h1F;
            power_control_output <= 1'b0;
            serial_tx <= 1'b1;
            msg_char <= 8'h00;
            msg_char_valid <= 1'b0;
            msg_done <= 1'b0;
            wake_cnt <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            step <= next_step;
            len <= next_len;
            c0 <= next_c0;
            c1 <= next_c1;
            c2 <= next_c2;
            c3 <= next_c3;
            bad <= next_bad;
            lf_on <= next_lf_on;
            kind <= next_kind;
            indicator <= next_indicator;
            power_control_output <= next_pwr;
            serial_tx <= next_tx;
            msg_char <= next_fwd;
            msg_char_valid <= next_fwd_valid;
            msg_done <= next_done;
            wake_cnt <= next_wake_cnt;
        end
    end

    a_prompt_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == ST_PROMPT && tx_ready |=> state == ST_IDLE)
        else $error("prompt not followed by idle");
    a_exec_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == ST_EXEC && !exec_done && !sleep_warning_message |=> state == ST_EXEC)
        else $error("prompt sent during execution");
    a_pwr_normal: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == ST_IDLE |-> power_control_output == $past(power_normal_level))
        else $error("power control left normal level");
    a_cr_needed: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == ST_IDLE && !rx_valid && !sleep_warning_message && timer < TW'(ABORT_CYC - 1)
        |=> state == ST_IDLE)
        else $error("message acted on without terminator");
    a_hex_forward: assert property (@(posedge ref_clk) disable iff (!rst_n)
        msg_done |-> $past(rx_valid) && $past(ch) == `CHR_CR)
        else $error("forward without carriage return");
    a_reset_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == ST_ANSWER && kind == MSG_FULL_RESET && !bad |=> state == ST_WAIT
        && timer == TW'(FULL_RESET_CYC - 1))
        else $error("full reset delay wrong");
    a_sleep_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == ST_ANSWER && kind == MSG_SLEEP && !bad && !sleep_warning_message
        |=> timer == TW'(SLEEP_REQ_CYC - 1))
        else $error("sleep delay wrong");
    a_volt_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == ST_ANSWER && kind == MSG_VOLT && !bad |=> timer == TW'(ADC_CYC - 1))
        else $error("voltage delay wrong");
endmodule

// >>> verif/host_term.sv
/*
 Host terminal model: sends and hears 8N1 characters at a fixed bit period.
 Assumes the device line idles high and the bench calls the send tasks at a clock edge.
*/
`timescale 1ns/10ps
module host_term #(
    parameter int BIT_CYC = 651
) (
    // Clock
    input wire logic clk,
    // Serial lines
    input wire logic dev_tx,
    output logic host_tx
);
    logic [7:0] heard[$];
    logic [7:0] sh;

    initial host_tx = 1'b1;

    // Start bit, eight data bits LSB first, one stop bit
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            host_tx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask

    // Low pulse on the idle-high line to wake the device
    task automatic wake_pulse(input int cyc);
        host_tx <= 1'b0;
        repeat (cyc) @(posedge clk);
        host_tx <= 1'b1;
        repeat (BIT_CYC) @(posedge clk);
    endtask

    // Samples mid-bit; a frame with a low stop bit is dropped
    initial begin
        forever begin
            @(negedge dev_tx);
            repeat (BIT_CYC / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge clk);
                sh[i] = dev_tx;
            end
            repeat (BIT_CYC) @(posedge clk);
            if (dev_tx === 1'b1) heard.push_back(sh);
        end
    end
endmodule

// >>> verif/serial_host_command_front_end_tb.sv
/*
 Self-checking bench for the command front end with a host terminal model.
 Assumes shortened delay parameters; the line runs at the fast rate.
*/
`timescale 1ns/10ps
`include "cmd_front_map.svh"
module serial_host_command_front_end_tb;
    import cmd_front_pkg::*;
    localparam int BIT = `CLK_HZ / `BAUD_FAST;
    localparam int LED = 50;
    localparam int SREQ = 2000;
    localparam int SWARN = 4000;
    // Identity character value is arbitrary
    localparam logic [7:0] IDB = 8'h49;
    logic ref_clk, rst_b, rate_select, power_normal_level, exec_done, sleep_warning_message;
    logic serial_rx, serial_tx, power_control_output, msg_char_valid, msg_done;
    logic [4:0] indicator;
    logic [7:0] msg_char, last_fwd, c, d;
    int n_errors, cmp_count, seed, n_done, k;
    string s;

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Abort must outlast a six-character message at the fast rate
    cmd_front_end #(.ABORT_CYC(36000), .FULL_RESET_CYC(200), .SLEEP_REQ_CYC(SREQ),
        .SLEEP_WARN_CYC(SWARN), .ADC_CYC(150), .WARM_CYC(100), .LED_STEP_CYC(LED),
        .ID_BYTE(IDB)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .rate_select(rate_select),
        .power_normal_level(power_normal_level), .serial_rx(serial_rx),
        .serial_tx(serial_tx), .indicator(indicator),
        .power_control_output(power_control_output), .msg_char(msg_char),
        .msg_char_valid(msg_char_valid), .msg_done(msg_done), .exec_done(exec_done),
        .sleep_warning_message(sleep_warning_message));

    host_term #(.BIT_CYC(BIT)) host_u (.clk(ref_clk), .dev_tx(serial_tx), .host_tx(serial_rx));

    always @(posedge ref_clk) begin
        if (msg_char_valid === 1'b1) last_fwd <= msg_char;
        if (msg_done === 1'b1) n_done++;
    end

    task automatic results();
        $display("counts: %0d compared, %0d mismatched", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic compare_char(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected char at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic compare_level(input logic [4:0] got, input logic [4:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected level at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait for the next heard character
    task automatic get_char(output logic [7:0] ch);
        for (int i = 0; i < 50000 && host_u.heard.size() == 0; i++) @(posedge ref_clk);
        if (host_u.heard.size() == 0) begin
            n_errors++;
            $display("unexpected silence at %0t: got %h expected %h", $time, 8'h00, 8'h3E);
            results();
        end
        ch = host_u.heard.pop_front();
    endtask

    task automatic expect_end();
        get_char(c);
        compare_char(c, `CHR_CR);
        get_char(c);
        if (c === `CHR_LF) get_char(c);
        compare_char(c, `CHR_PROMPT);
    endtask

    task automatic send_str(input string t);
        for (int i = 0; i < t.len(); i++) host_u.send_byte(t[i]);
    endtask

    task automatic banner();
        for (int i = 0; i < 4; i++) begin
            get_char(c);
            compare_char(c, IDB);
        end
        expect_end();
    endtask

    function automatic logic [7:0] up(input logic [7:0] x);
        return (x >= 8'h61) ? x - 8'h20 : x;
    endfunction

    initial begin
        seed = 88;
        rst_b = 1'b0;
        rate_select = 1'b1;
        power_normal_level = 1'b0;
        exec_done = 1'b0;
        sleep_warning_message = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        n_done = 0;
        power_normal_level <= $random(seed);
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            d = {3'h0, indicator};
            for (k = 0; k < 3 * LED && indicator === d[4:0]; k++) @(posedge ref_clk);
            compare_level(indicator, ~(5'h01 << i));
        end
        banner();
        compare_level({4'h0, power_control_output}, {4'h0, power_normal_level});
        $display("test power_up done");
        s = "0123456789abcdef";
        d = s[$unsigned($random(seed)) % 16];
        send_str({s[$unsigned($random(seed)) % 16], "1 2", d, "\r"});
        repeat (50) @(posedge ref_clk);
        compare_level(n_done[4:0], 5'h01);
        compare_char(last_fwd, up(d));
        repeat (2000) @(posedge ref_clk);
        compare_level(5'(host_u.heard.size()), 5'h00);
        exec_done <= 1'b1;
        @(posedge ref_clk);
        exec_done <= 1'b0;
        get_char(c);
        compare_char(c, `CHR_PROMPT);
        $display("test hex_message done");
        c = 8'h47 + ($unsigned($random(seed)) % 20);
        send_str({"0", c, "\r"});
        get_char(c);
        compare_char(c, `CHR_QMARK);
        expect_end();
        compare_level(n_done[4:0], 5'h01);
        send_str("1");
        get_char(c);
        compare_char(c, `CHR_QMARK);
        expect_end();
        $display("test errors done");
        send_str("A T Z\r");
        banner();
        $display("test full_reset done");
        send_str("ATLP\r");
        for (k = 0; k < 2 * SREQ && power_control_output === power_normal_level; k++)
            @(posedge ref_clk);
        compare_level({4'h0, k > SREQ - BIT && k < SREQ + 20}, 5'h01);
        host_u.wake_pulse(3300);
        for (k = 0; k < 2000 && power_control_output !== power_normal_level; k++)
            @(posedge ref_clk);
        compare_level({4'h0, power_control_output}, {4'h0, power_normal_level});
        sleep_warning_message <= 1'b1;
        @(posedge ref_clk);
        sleep_warning_message <= 1'b0;
        for (k = 0; k < 2 * SWARN && power_control_output === power_normal_level; k++)
            @(posedge ref_clk);
        compare_level({4'h0, k > SWARN - 5 && k < SWARN + 5}, 5'h01);
        $display("test sleep done");
        results();
    end
endmodule
